// ### core/plw_pkg.sv
// constants for the program loop watchdog
package plw_pkg;
  localparam logic [15:0] WATCHDOG_MODE_ADDR = 16'hff48;
  localparam logic [15:0] WATCHDOG_RESTART_KEY_ADDR = 16'hff49;
  localparam logic [7:0] MODE_RESET = 8'h67;
  localparam logic [7:0] KEY_READ_VALUE = 8'h9a;
  localparam logic [7:0] RESTART_KEY = 8'hac;
  localparam logic [2:0] MODE_FIXED_HI = 3'h3;
  localparam int CLK_SEL_HI_BIT = 4;
  localparam int CLK_SEL_LO_BIT = 3;
  localparam int CAUSE_FLAG_BIT = 4;
  localparam int SLOW_BASE_EXP = 11;
  localparam int MAIN_BASE_EXP = 13;
  localparam int CNT_W = 21;
endpackage

// ### core/plw_watchdog.sv
// program loop watchdog: mode and restart-key registers, counter, reset
// Notes on behaviour
// - overflow at selected count without restart raises internal reset request
// - watchdog-caused reset sets cause flag bit 4 of reset-cause register
// - clock select 00 slow osc, 01 main clock, 1x stops counting
// - interval k gives 2^(11+k) slow or 2^(13+k) main clock cycles
// - after reset count at once on slow osc at longest interval
// - reset loads mode register with 67h
// - one byte write to mode allowed; another write raises reset
// - if first write stopped watchdog, later violations raise no reset
// - non-stoppable variant ignores clock select, always slow osc
// - non-stoppable changes interval once; stoppable sets source and interval
// - byte write of ach to key clears counter, counting continues
// - byte write of other value to key raises reset
// - any bit write to key register raises reset
// - key register reads 9ah always
// - main clock source pauses when main clock stopped, standby, stab wait
// - slow source pauses in standby or when slow osc stopped
// - counter clears on the first byte write to the mode register
// - stoppable variant resumes after standby keeping count
`timescale 1ns/1ps
`default_nettype none
module plw_watchdog (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire logic bit_op,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic slow_osc_tick,
  input wire logic main_clk_tick,
  input wire logic main_clk_running,
  input wire logic slow_osc_running,
  input wire logic standby,
  input wire logic stab_wait,
  input wire logic osc_fixed_opt,
  output logic wdt_reset_req,
  output logic watchdog_cause_flag
);
  logic [7:0] watchdog_mode_reg;
  logic mode_written;
  logic fixed_mode;
  logic [plw_pkg::CNT_W-1:0] count;
  logic [plw_pkg::CNT_W-1:0] limit;
  logic stopped;
  logic main_src;
  logic tick;
  logic mode_wr;
  logic key_wr;
  logic violation;
  logic overflow;
  logic [4:0] exp_sel;

  assign mode_wr = wr_en && addr == plw_pkg::WATCHDOG_MODE_ADDR;
  assign key_wr = wr_en && addr == plw_pkg::WATCHDOG_RESTART_KEY_ADDR;

  // decoded mode; fixed variant forces slow osc and never stops
  assign stopped = !fixed_mode &&
    watchdog_mode_reg[plw_pkg::CLK_SEL_HI_BIT];
  assign main_src = !fixed_mode &&
    !watchdog_mode_reg[plw_pkg::CLK_SEL_HI_BIT] &&
    watchdog_mode_reg[plw_pkg::CLK_SEL_LO_BIT];

  // count enable; pauses without clearing the count
  always_comb begin
    if (stopped) begin
      tick = 1'b0;
    end else if (main_src) begin
      tick = main_clk_tick && main_clk_running && !standby &&
        !stab_wait;
    end else begin
      tick = slow_osc_tick && slow_osc_running && !standby;
    end
  end

  // overflow count from interval and source
  always_comb begin
    exp_sel = 5'(watchdog_mode_reg[2:0]) + (main_src ?
      5'(plw_pkg::MAIN_BASE_EXP) : 5'(plw_pkg::SLOW_BASE_EXP));
    limit = plw_pkg::CNT_W'(1) << exp_sel;
  end

  assign overflow = tick && (count == limit - plw_pkg::CNT_W'(1));

  // bus violations, all waived once the first write stopped the watchdog
  assign violation = !stopped && (
    (mode_wr && (mode_written || bit_op)) ||
    (key_wr && bit_op) ||
    (key_wr && !bit_op && wdata != plw_pkg::RESTART_KEY));

  // option sampled while reset is held, frozen afterwards
  always_ff @(posedge mclk) begin
    if (reset) begin
      fixed_mode <= osc_fixed_opt;
    end
  end

  // mode register: one byte write accepted after reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      watchdog_mode_reg <= plw_pkg::MODE_RESET;
      mode_written <= 1'b0;
    end else if (mode_wr && !bit_op && !mode_written) begin
      mode_written <= 1'b1;
      // top bits forced to 0,1,1 whatever software writes to them
      watchdog_mode_reg <= {plw_pkg::MODE_FIXED_HI, fixed_mode ?
        {2'b00, wdata[2:0]} : wdata[4:0]};
    end
  end

  // counter: cleared by restart key, first mode write or overflow
  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
    end else if (mode_wr && !bit_op && !mode_written) begin
      count <= '0;
    end else if (key_wr && !bit_op && wdata == plw_pkg::RESTART_KEY) begin
      count <= '0;
    end else if (overflow) begin
      count <= '0;
    end else if (tick) begin
      count <= count + plw_pkg::CNT_W'(1);
    end
  end

  // reset request pulse; system reset comes back through reset input
  always_ff @(posedge mclk) begin
    if (reset) begin
      wdt_reset_req <= 1'b0;
    end else begin
      wdt_reset_req <= overflow || violation;
    end
  end

  // cause flag set by our own reset request; every reset keeps it, nothing clears it
  always_ff @(posedge mclk) begin
    if (wdt_reset_req) begin
      watchdog_cause_flag <= 1'b1;
    end else if (reset) begin
      watchdog_cause_flag <= watchdog_cause_flag;
    end
  end

  // read data; key register always reads fixed value
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd_en && addr == plw_pkg::WATCHDOG_MODE_ADDR) begin
      rdata <= watchdog_mode_reg;
    end else if (rd_en && addr == plw_pkg::WATCHDOG_RESTART_KEY_ADDR) begin
      rdata <= plw_pkg::KEY_READ_VALUE;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### testbench/plw_watchdog_chk.sv
// port-level assertions for the program loop watchdog
`timescale 1ns/1ps
`default_nettype none
module plw_watchdog_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic bit_op,
  input wire logic rd_en,
  input wire logic osc_fixed_opt,
  input wire logic wdt_reset_req,
  input wire logic watchdog_cause_flag,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  logic mw, st; // mode written once; watchdog stopped by that write
  wire wm = wr_en && addr == plw_pkg::WATCHDOG_MODE_ADDR;
  wire wk = wr_en && addr == plw_pkg::WATCHDOG_RESTART_KEY_ADDR;
  // only the first mode write may stop it, never in the fixed variant
  always_ff @(posedge mclk) begin
    if (reset) begin
      mw <= 1'b0;
      st <= 1'b0;
    end else if (wm && !bit_op) begin
      mw <= 1'b1;
      if (!mw) st <= wdata[4] && !osc_fixed_opt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_pulse;
    wdt_reset_req ##1 !wdt_reset_req;
  endsequence
  a_key_bad:
    assert property (wk && !bit_op && wdata != plw_pkg::RESTART_KEY && !st
      |=> wdt_reset_req) else $error("wrong key gave no reset request");
  a_key_bit:
    assert property (wk && bit_op && !st |=> wdt_reset_req)
      else $error("bit access to key gave no reset request");
  a_mode_twice:
    assert property (wm && mw && !st |=> wdt_reset_req)
      else $error("second mode write gave no reset request");
  a_stop_quiet:
    assert property (st && $past(st) |-> !wdt_reset_req)
      else $error("stopped watchdog requested reset");
  a_key_read:
    assert property (rd_en && addr == plw_pkg::WATCHDOG_RESTART_KEY_ADDR
      |=> rdata == plw_pkg::KEY_READ_VALUE) else $error("key read wrong");
  a_mode_reset:
    assert property (rd_en && addr == plw_pkg::WATCHDOG_MODE_ADDR && !mw
      |=> rdata == plw_pkg::MODE_RESET) else $error("mode reset value wrong");
  a_req_pulse:
    assert property (wdt_reset_req |-> s_pulse)
      else $error("reset request not a single pulse");
  a_cause_set:
    assert property (wdt_reset_req |=> watchdog_cause_flag)
      else $error("cause flag not set");
  a_good_key:
    assert property (wk && !bit_op && wdata == plw_pkg::RESTART_KEY
      |=> !wdt_reset_req) else $error("right key gave reset request");
endmodule
bind plw_watchdog plw_watchdog_chk chk_i (.mclk(mclk), .reset(reset),
  .wr_en(wr_en), .bit_op(bit_op), .rd_en(rd_en), .addr(addr),
  .wdata(wdata), .rdata(rdata), .osc_fixed_opt(osc_fixed_opt),
  .wdt_reset_req(wdt_reset_req), .watchdog_cause_flag(watchdog_cause_flag));
`default_nettype wire

// ### testbench/program_loop_watchdog_test.sv
// self-checking bench for the program loop watchdog
`timescale 1ns/1ps
`default_nettype none
module program_loop_watchdog_test;
  logic mclk = 0, reset = 1, wr_en = 0, bit_op = 0, rd_en = 0, sb = 0;
  logic opt = 0, tk = 1, req, cause, q;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, r;
  int fails = 0, total_checks = 0;
  // addr, data, bit access, expected request; reset before each row
  logic [25:0] rows [4] = '{{16'hff49, 8'hac, 2'h0}, {16'hff49, 8'h55, 2'h1},
    {16'hff49, 8'hac, 2'h3}, {16'hff48, 8'h60, 2'h0}};
  plw_watchdog uut (.mclk(mclk), .reset(reset), .addr(addr), .wr_en(wr_en),
    .bit_op(bit_op), .rd_en(rd_en), .wdata(wdata), .rdata(rdata),
    .slow_osc_tick(tk), .main_clk_tick(tk), .main_clk_running(1'b1),
    .slow_osc_running(1'b1), .standby(sb), .stab_wait(1'b0),
    .osc_fixed_opt(opt), .wdt_reset_req(req), .watchdog_cause_flag(cause));
  initial forever #50 mclk = ~mclk;
  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task rst(input logic f);
    opt <= f;
    reset <= 1;
    repeat (8) @(posedge mclk);
    reset <= 0;
  endtask
  // one access; request captured over the two cycles after it is taken
  task acc(input [15:0] a, input [7:0] d, input b, input w);
    @(posedge mclk);
    addr <= a; wdata <= d; bit_op <= b; wr_en <= w; rd_en <= !w;
    @(posedge mclk);
    wr_en <= 0; rd_en <= 0; bit_op <= 0;
    #1 r = rdata;
    q = req;
    @(posedge mclk);
    #1 q = q | req;
  endtask
  // cycles from mode write to overflow, standby held for s cycles
  task ovf(input [7:0] m, input logic f, input int s, input int e);
    int n;
    n = 1;
    rst(f);
    acc(16'hff48, m, 0, 1);
    while (req !== 1'b1 && n < 9000) begin
      @(posedge mclk);
      sb <= (n < s + 1);
      #1 n++;
    end
    chk({7'h0, n >= e + s - 2 && n <= e + s + 2}, 8'h01);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    foreach (rows[i]) begin
      rst(0);
      acc(rows[i][25:10], rows[i][9:2], rows[i][1], 1);
      chk({7'h0, q}, {7'h0, rows[i][0]});
    end
    rst(0);
    acc(16'hff48, 0, 0, 0);
    chk(r, plw_pkg::MODE_RESET);
    acc(16'hff49, 8'hac, 0, 1);
    acc(16'hff49, 0, 0, 0);
    chk(r, plw_pkg::KEY_READ_VALUE);
    acc(16'hff4a, 0, 0, 0);
    chk(r, 8'h00);
    acc(16'hff48, 8'h60, 0, 1);
    acc(16'hff48, 8'h60, 0, 1);
    chk({7'h0, q}, 8'h01);
    chk({7'h0, cause}, 8'h01);
    rst(0);
    acc(16'hff48, 8'h70, 0, 1);
    acc(16'hff48, 0, 0, 0);
    chk(r, 8'h70);
    acc(16'hff49, 8'h55, 0, 1);
    chk({7'h0, q}, 8'h00);
    acc(16'hff48, 8'h60, 0, 1);
    chk({7'h0, q}, 8'h00);
    ovf(8'h60, 0, 0, 2048);
    ovf(8'h68, 0, 50, 8192);
    ovf(8'h68, 1, 0, 2048);
    final_report;
  end
  // cut a hang short well after the expected run of about 1.25 ms
  initial begin
    #4000000;
    fails++;
    final_report;
  end
endmodule
`default_nettype wire
